/* File: logic/mst_top.sv */
// magnetometer register file, measurement timing and serial access
`timescale 1ns/100ps
module mst_top
  import mst_pkg::*;
#(
  parameter int MEAS_PERIOD = mst_pkg::MEAS_PERIOD_CYC
)(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // serial pins
  input  wire logic               spiCsN,
  input  wire logic               spiSck,
  input  wire logic               spiSdi,
  output logic                    spiSdo,
  output logic                    spiSdoOeN,
  // analog front end
  output logic                    adcReq,
  output logic                    strapSet,
  output logic                    offsetStrapEn,
  output logic                    offsetStrapNeg,
  output logic [2:0]              gainSel,
  input  wire logic               adcDone,
  input  wire logic signed [15:0] adcX,
  input  wire logic signed [15:0] adcY,
  input  wire logic signed [15:0] adcZ,
  // data ready indication
  output logic                    data_ready_pin
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic isData(input logic [5:0] a);
    isData = (a >= ADDR_X_HIGH) && (a <= ADDR_Y_LOW);
  endfunction

  function automatic logic [2:0] dataIndex(input logic [5:0] a);
    logic [5:0] d;
    d         = a - ADDR_X_HIGH;
    dataIndex = d[2:0];
  endfunction

  // ****************************************
  // serial port
  // ****************************************
  logic [5:0] regAddr, accessAddr;
  logic [7:0] rdData, wrData;
  logic       wrStrobe, rdStrobe;

  mst_spi u_spi (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .spiCsN     (spiCsN),
    .spiSck     (spiSck),
    .spiSdi     (spiSdi),
    .spiSdo     (spiSdo),
    .spiSdoOeN  (spiSdoOeN),
    .regAddr    (regAddr),
    .rdData     (rdData),
    .accessAddr (accessAddr),
    .wrStrobe   (wrStrobe),
    .wrData     (wrData),
    .rdStrobe   (rdStrobe)
  );

  // ****************************************
  // acquisition
  // ****************************************
  logic               startMeas, acqBusy, resValid;
  logic signed [15:0] resX, resY, resZ;
  logic [7:0]         measCfg;

  mst_acq u_acq (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .start          (startMeas),
    .bias           (measCfg[1:0]),
    .busy           (acqBusy),
    .adcReq         (adcReq),
    .strapSet       (strapSet),
    .offsetStrapEn  (offsetStrapEn),
    .offsetStrapNeg (offsetStrapNeg),
    .adcDone        (adcDone),
    .adcX           (adcX),
    .adcY           (adcY),
    .adcZ           (adcZ),
    .resValid       (resValid),
    .resX           (resX),
    .resY           (resY),
    .resZ           (resZ)
  );

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  gainCfg, modeReg;
  logic [7:0]  next_measCfg, next_gainCfg, next_modeReg;
  logic [15:0] dataX, dataY, dataZ;
  logic [15:0] next_dataX, next_dataY, next_dataZ;
  logic [5:0]  readMask, next_readMask;
  logic        dataReady, next_dataReady;
  logic        singlePend, next_singlePend;
  logic [2:0]  next_gainSel, gainPend, next_gainPend;
  logic [31:0] timer, next_timer;
  logic        locked, periodDone;

  // a half-read set stays frozen so the host never mixes two sets
  assign locked     = (readMask != ALL_READ);
  assign periodDone = (timer == 32'h0000_0000);
  assign startMeas  = !acqBusy &&
                      (singlePend ||
                       (modeReg[1:0] == MODE_CONT && periodDone));

  always_comb begin
    rdData = 8'h00;
    unique case (regAddr)
      ADDR_MEAS_CFG: rdData = measCfg;
      ADDR_GAIN:     rdData = gainCfg;
      ADDR_MODE:     rdData = modeReg;
      6'h03:         rdData = dataX[15:8];
      6'h04:         rdData = dataX[7:0];
      6'h05:         rdData = dataZ[15:8];
      6'h06:         rdData = dataZ[7:0];
      6'h07:         rdData = dataY[15:8];
      ADDR_Y_LOW:    rdData = dataY[7:0];
      ADDR_STATUS: begin
        rdData[STAT_RDY_BIT]  = dataReady;
        rdData[STAT_LOCK_BIT] = locked;
      end
      default:       rdData = 8'h00;
    endcase
  end

  always_comb begin
    next_measCfg    = measCfg;
    next_gainCfg    = gainCfg;
    next_modeReg    = modeReg;
    next_dataX      = dataX;
    next_dataY      = dataY;
    next_dataZ      = dataZ;
    next_readMask   = readMask;
    next_dataReady  = dataReady;
    next_singlePend = singlePend && !startMeas;
    next_gainSel    = gainSel;
    next_gainPend   = gainPend;
    next_timer      = periodDone ? 32'(MEAS_PERIOD - 1) : timer - 32'h1;
    if (startMeas) begin
      // front end runs one start behind the register, so the first
      // set after a gain write still carries the old gain
      next_gainSel  = gainPend;
      next_gainPend = gainCfg[GAIN_LSB +: 3];
      if (modeReg[1:0] == MODE_SINGLE)
        next_modeReg = {modeReg[7:2], MODE_IDLE};
    end
    if (wrStrobe) begin
      unique case (accessAddr)
        ADDR_MEAS_CFG: next_measCfg = wrData;
        ADDR_GAIN:     next_gainCfg = wrData;
        ADDR_MODE: begin
          next_modeReg = wrData;
          next_singlePend = (wrData[1:0] == MODE_SINGLE);
        end
        default: ;
      endcase
    end
    if (rdStrobe && isData(accessAddr)) begin
      next_readMask[dataIndex(accessAddr)] = 1'b1;
      next_dataReady = 1'b0;
    end
    // a new set wins over a read that clears ready in the same cycle
    if (resValid && !locked) begin
      next_dataX     = resX;
      next_dataY     = resY;
      next_dataZ     = resZ;
      next_readMask  = 6'h00;
      next_dataReady = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      measCfg    <= MEAS_CFG_RST;
      gainCfg    <= GAIN_RST;
      modeReg    <= MODE_RST;
      dataX      <= 16'h0000;
      dataY      <= 16'h0000;
      dataZ      <= 16'h0000;
      readMask   <= ALL_READ;
      dataReady  <= 1'b0;
      singlePend <= 1'b0;
      gainSel    <= GAIN_RST[GAIN_LSB +: 3];
      gainPend   <= GAIN_RST[GAIN_LSB +: 3];
      timer      <= 32'h0000_0000;
    end else begin
      measCfg    <= next_measCfg;
      gainCfg    <= next_gainCfg;
      modeReg    <= next_modeReg;
      dataX      <= next_dataX;
      dataY      <= next_dataY;
      dataZ      <= next_dataZ;
      readMask   <= next_readMask;
      dataReady  <= next_dataReady;
      singlePend <= next_singlePend;
      gainSel    <= next_gainSel;
      gainPend   <= next_gainPend;
      timer      <= next_timer;
    end
  end

  assign data_ready_pin = dataReady;
endmodule

/* File: logic/mst_pkg.sv */
// constants and types for the magnetometer self-test access block
package mst_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] ADDR_MEAS_CFG = 6'h00;
  localparam logic [5:0] ADDR_GAIN     = 6'h01;
  localparam logic [5:0] ADDR_MODE     = 6'h02;
  localparam logic [5:0] ADDR_X_HIGH   = 6'h03;
  localparam logic [5:0] ADDR_Y_LOW    = 6'h08;
  localparam logic [5:0] ADDR_STATUS   = 6'h09;
  localparam logic [7:0] MEAS_CFG_RST  = 8'h10;
  localparam logic [7:0] GAIN_RST      = 8'h20;
  localparam logic [7:0] MODE_RST      = 8'h01;
  // ****************************************
  // fields and encodings
  // ****************************************
  localparam int         CMD_READ_BIT  = 7;
  localparam int         CMD_INC_BIT   = 6;
  localparam int         GAIN_LSB      = 5;
  localparam int         STAT_RDY_BIT  = 0;
  localparam int         STAT_LOCK_BIT = 1;
  localparam logic [1:0] BIAS_NORMAL   = 2'h0;
  localparam logic [1:0] BIAS_POS      = 2'h1;
  localparam logic [1:0] BIAS_NEG      = 2'h2;
  localparam logic [1:0] MODE_CONT     = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;
  localparam logic [1:0] MODE_IDLE     = 2'h3;
  localparam logic [5:0] ALL_READ      = 6'h3F;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int MEAS_RATE_HZ    = 15;
  localparam int MEAS_PERIOD_CYC = CLK_HZ / MEAS_RATE_HZ;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_BASE, ACQ_BIAS} mst_acq_t;
endpackage

/* File: logic/mst_spi.sv */
// serial port slave: command byte, address pointer, byte strobes
`timescale 1ns/100ps
module mst_spi
  import mst_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // serial pins
  input  wire logic       spiCsN,
  input  wire logic       spiSck,
  input  wire logic       spiSdi,
  output logic            spiSdo,
  output logic            spiSdoOeN,
  // register side
  output logic [5:0]      regAddr,
  input  wire logic [7:0] rdData,
  output logic [5:0]      accessAddr,
  output logic            wrStrobe,
  output logic [7:0]      wrData,
  output logic            rdStrobe
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] csSync, sckSync, sdiSync;
  logic       sckPrev;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csSync  <= 2'h3;
      sckSync <= 2'h3;
      sdiSync <= 2'h0;
      sckPrev <= 1'b1;
    end else begin
      csSync  <= {csSync[0], spiCsN};
      sckSync <= {sckSync[0], spiSck};
      sdiSync <= {sdiSync[0], spiSdi};
      sckPrev <= sckSync[1];
    end
  end
  wire active = !csSync[1];
  wire rise   = active && sckSync[1] && !sckPrev;
  wire fall   = active && !sckSync[1] && sckPrev;
  // ****************************************
  // frame engine
  // ****************************************
  logic [2:0] bitCnt, next_bitCnt;
  logic [7:0] rxShift, next_rxShift, txShift, next_txShift;
  logic       cmdDone, next_cmdDone, isRead, next_isRead;
  logic       autoInc, next_autoInc, driving, next_driving;
  logic [5:0] next_regAddr, next_accessAddr;
  logic       next_wrStrobe, next_rdStrobe;
  logic [7:0] next_wrData;
  logic [7:0] rxByte;
  always_comb begin
    rxByte          = {rxShift[6:0], sdiSync[1]};
    next_bitCnt     = bitCnt;
    next_rxShift    = rxShift;
    next_txShift    = txShift;
    next_cmdDone    = cmdDone;
    next_isRead     = isRead;
    next_autoInc    = autoInc;
    next_driving    = driving;
    next_regAddr    = regAddr;
    next_accessAddr = accessAddr;
    next_wrStrobe   = 1'b0;
    next_rdStrobe   = 1'b0;
    next_wrData     = wrData;
    if (!active) begin
      next_bitCnt  = 3'h0;
      next_cmdDone = 1'b0;
      next_driving = 1'b0;
    end else if (rise) begin
      next_rxShift = rxByte;
      next_bitCnt  = bitCnt + 3'h1;
      if (bitCnt == 3'h7) begin
        if (!cmdDone) begin
          next_cmdDone = 1'b1;
          next_isRead  = rxByte[CMD_READ_BIT];
          next_autoInc = rxByte[CMD_INC_BIT];
          next_regAddr = rxByte[5:0];
        end else if (!isRead) begin
          next_wrStrobe   = 1'b1;
          next_wrData     = rxByte;
          next_accessAddr = regAddr;
          if (autoInc)
            next_regAddr = regAddr + 6'h01;
        end
      end
    end else if (fall && cmdDone && isRead) begin
      // a byte is fetched at its first falling edge, then shifted out
      if (bitCnt == 3'h0) begin
        next_txShift    = rdData;
        next_rdStrobe   = 1'b1;
        next_accessAddr = regAddr;
        next_driving    = 1'b1;
        if (autoInc)
          next_regAddr = regAddr + 6'h01;
      end else begin
        next_txShift = {txShift[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bitCnt     <= 3'h0;
      rxShift    <= 8'h00;
      txShift    <= 8'h00;
      cmdDone    <= 1'b0;
      isRead     <= 1'b0;
      autoInc    <= 1'b0;
      driving    <= 1'b0;
      regAddr    <= 6'h00;
      accessAddr <= 6'h00;
      wrStrobe   <= 1'b0;
      rdStrobe   <= 1'b0;
      wrData     <= 8'h00;
    end else begin
      bitCnt     <= next_bitCnt;
      rxShift    <= next_rxShift;
      txShift    <= next_txShift;
      cmdDone    <= next_cmdDone;
      isRead     <= next_isRead;
      autoInc    <= next_autoInc;
      driving    <= next_driving;
      regAddr    <= next_regAddr;
      accessAddr <= next_accessAddr;
      wrStrobe   <= next_wrStrobe;
      rdStrobe   <= next_rdStrobe;
      wrData     <= next_wrData;
    end
  end
  assign spiSdo    = txShift[7];
  assign spiSdoOeN = !driving;
endmodule

/* File: logic/mst_acq.sv */
// acquisition sequencer: plain or paired self-test acquisitions
`timescale 1ns/100ps
module mst_acq
  import mst_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // control
  input  wire logic               start,
  input  wire logic [1:0]         bias,
  output logic                    busy,
  // front end
  output logic                    adcReq,
  output logic                    strapSet,
  output logic                    offsetStrapEn,
  output logic                    offsetStrapNeg,
  input  wire logic               adcDone,
  input  wire logic signed [15:0] adcX,
  input  wire logic signed [15:0] adcY,
  input  wire logic signed [15:0] adcZ,
  // result
  output logic                    resValid,
  output logic signed [15:0]      resX,
  output logic signed [15:0]      resY,
  output logic signed [15:0]      resZ
);
  mst_acq_t          state, next_state;
  logic              selfTest, next_selfTest, next_neg;
  logic              next_adcReq, next_strapSet, next_resValid;
  logic signed [15:0] baseX, baseY, baseZ;
  logic signed [15:0] next_baseX, next_baseY, next_baseZ;
  logic signed [15:0] next_resX, next_resY, next_resZ;
  always_comb begin
    next_state    = state;
    next_selfTest = selfTest;
    next_neg      = offsetStrapNeg;
    next_adcReq   = 1'b0;
    next_strapSet = 1'b0;
    next_resValid = 1'b0;
    next_baseX    = baseX;
    next_baseY    = baseY;
    next_baseZ    = baseZ;
    next_resX     = resX;
    next_resY     = resY;
    next_resZ     = resZ;
    unique case (state)
      ACQ_IDLE: if (start) begin
        // bias 11 is not a test code, so it measures plainly
        next_selfTest = (bias == BIAS_POS) || (bias == BIAS_NEG);
        next_neg      = (bias == BIAS_NEG);
        next_strapSet = next_selfTest;
        next_adcReq   = 1'b1;
        next_state    = ACQ_BASE;
      end
      ACQ_BASE: if (adcDone) begin
        if (selfTest) begin
          next_baseX  = adcX;
          next_baseY  = adcY;
          next_baseZ  = adcZ;
          next_adcReq = 1'b1;
          next_state  = ACQ_BIAS;
        end else begin
          next_resX     = adcX;
          next_resY     = adcY;
          next_resZ     = adcZ;
          next_resValid = 1'b1;
          next_state    = ACQ_IDLE;
        end
      end
      ACQ_BIAS: if (adcDone) begin
        next_resX     = adcX - baseX;
        next_resY     = adcY - baseY;
        next_resZ     = adcZ - baseZ;
        next_resValid = 1'b1;
        next_state    = ACQ_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state          <= ACQ_IDLE;
      selfTest       <= 1'b0;
      offsetStrapNeg <= 1'b0;
      adcReq         <= 1'b0;
      strapSet       <= 1'b0;
      resValid       <= 1'b0;
      baseX          <= 16'sh0000;
      baseY          <= 16'sh0000;
      baseZ          <= 16'sh0000;
      resX           <= 16'sh0000;
      resY           <= 16'sh0000;
      resZ           <= 16'sh0000;
    end else begin
      state          <= next_state;
      selfTest       <= next_selfTest;
      offsetStrapNeg <= next_neg;
      adcReq         <= next_adcReq;
      strapSet       <= next_strapSet;
      resValid       <= next_resValid;
      baseX          <= next_baseX;
      baseY          <= next_baseY;
      baseZ          <= next_baseZ;
      resX           <= next_resX;
      resY           <= next_resY;
      resZ           <= next_resZ;
    end
  end
  // strap current flows only during the second acquisition
  assign offsetStrapEn = (state == ACQ_BIAS);
  assign busy          = (state != ACQ_IDLE);
endmodule

/* File: tb/mst_top_props.sv */
// concurrent checks on the magnetometer block ports
`timescale 1ns/100ps
module mst_top_props
  import mst_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // serial pins
  input wire logic       spiCsN,
  input wire logic       spiSdoOeN,
  // front end
  input wire logic       adcReq,
  input wire logic       strapSet,
  input wire logic       offsetStrapEn,
  input wire logic [2:0] gainSel,
  input wire logic       adcDone,
  input wire logic       data_ready_pin
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_set_first;
    strapSet |-> adcReq && !offsetStrapEn;
  endproperty
  a_set_first: assert property (p_set_first)
    else $error("set pulse outside first request");
  property p_strap_req;
    $rose(offsetStrapEn) |-> adcReq;
  endproperty
  a_strap_req: assert property (p_strap_req)
    else $error("strap on without request");
  property p_strap_hold;
    offsetStrapEn && !adcDone |=> offsetStrapEn;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap dropped early");
  property p_pair;
    $rose(offsetStrapEn) |-> $past(adcDone);
  endproperty
  a_pair: assert property (p_pair)
    else $error("second acquisition without baseline");
  property p_req_pulse;
    adcReq |=> !adcReq;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  property p_ready_src;
    $rose(data_ready_pin) |-> $past(adcDone, 2) || $past(adcDone, 3);
  endproperty
  a_ready_src: assert property (p_ready_src)
    else $error("ready without finished acquisition");
  property p_oe_idle;
    spiCsN [*6] |-> spiSdoOeN;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("sdo driven while deselected");
  property p_oe_sel;
    $fell(spiSdoOeN) |-> !spiCsN;
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("sdo enabled without select");
  property p_gain_hold;
    offsetStrapEn |-> $stable(gainSel);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain moved inside acquisition");
endmodule
bind mst_top mst_top_props u_props (
  .sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN), .spiSdoOeN(spiSdoOeN),
  .adcReq(adcReq), .strapSet(strapSet), .offsetStrapEn(offsetStrapEn),
  .gainSel(gainSel), .adcDone(adcDone), .data_ready_pin(data_ready_pin));

/* File: tb/mst_fe_model.sv */
// behavioural front end answering acquisition requests
`timescale 1ns/100ps
module mst_fe_model
  import mst_pkg::*;
(
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          rst,
  // requests
  input wire logic          adcReq,
  input wire logic          offsetStrapEn,
  input wire logic          offsetStrapNeg,
  input wire logic [2:0]    gainSel,
  // answers
  output logic              adcDone,
  output logic signed [15:0] adcX,
  output logic signed [15:0] adcY,
  output logic signed [15:0] adcZ
);
  int cnt, lat, sx, sz;
  logic slow, st;
  // alternate prompt and slow answers; idle samples toggle so stale
  // values never look valid
  always @(posedge sys_clk) begin
    adcDone <= 1'b0;
    adcX <= ~adcX;
    adcY <= ~adcY;
    adcZ <= ~adcZ;
    if (rst) begin
      lat <= 0;
      cnt <= 0;
      slow <= 1'b0;
    end else if (adcReq) begin
      lat <= slow ? 6 : 1;
      slow <= ~slow;
      st <= offsetStrapEn;
      if (!offsetStrapEn) cnt <= cnt + 1;
    end else if (lat == 1) begin
      lat <= 0;
      sx = st ? (offsetStrapNeg ? -452 : 452) : 0;
      sz = st ? (offsetStrapNeg ? -421 : 421) : 0;
      adcDone <= 1'b1;
      adcX <= 16'(1000 + cnt * 8 + sx);
      adcZ <= 16'(1200 + cnt * 8 + gainSel + sz);
      adcY <= 16'(700 + cnt * 8 + gainSel + sx);
    end else if (lat > 1) lat <= lat - 1;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the magnetometer access block
`timescale 1ns/100ps
module testbench;
  import mst_pkg::*;
  logic sys_clk, rst, spiCsN, spiSck, spiSdi, spiSdo, spiSdoOeN;
  logic adcReq, strapSet, offsetStrapEn, offsetStrapNeg, adcDone;
  logic data_ready_pin;
  logic [2:0] gainSel;
  logic signed [15:0] adcX, adcY, adcZ;
  logic [15:0] vx, vy, vz;
  logic [7:0] rxb[$];
  int fail_count = 0;
  int checked = 0;
  mst_top #(.MEAS_PERIOD(200)) DUT (
    .sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN),
    .adcReq(adcReq), .strapSet(strapSet), .offsetStrapEn(offsetStrapEn),
    .offsetStrapNeg(offsetStrapNeg), .gainSel(gainSel),
    .adcDone(adcDone), .adcX(adcX), .adcY(adcY), .adcZ(adcZ),
    .data_ready_pin(data_ready_pin));
  mst_fe_model u_fe (
    .sys_clk(sys_clk), .rst(rst), .adcReq(adcReq),
    .offsetStrapEn(offsetStrapEn), .offsetStrapNeg(offsetStrapNeg),
    .gainSel(gainSel), .adcDone(adcDone), .adcX(adcX), .adcY(adcY),
    .adcZ(adcZ));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one frame: command then n bytes; sdo taken late in the high phase
  task automatic xfer(input logic [7:0] cmd, input int n,
                      input logic [7:0] wv);
    logic [7:0] tx, sh;
    rxb = {};
    spiCsN = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int b = 0; b <= n; b++) begin
      tx = (b == 0) ? cmd : wv;
      for (int i = 7; i >= 0; i--) begin
        spiSck = 1'b0;
        spiSdi = tx[i];
        repeat (4) @(negedge sys_clk);
        spiSck = 1'b1;
        repeat (4) @(negedge sys_clk);
        sh = {sh[6:0], spiSdo};
      end
      if (b > 0) rxb.push_back(sh);
    end
    spiCsN = 1'b1;
    spiSdi = ~spiSdi;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    xfer(cmd, 1, 8'h00);
    chk({8'h00, rxb[0]}, {8'h00, exp});
  endtask
  task automatic rdset;
    xfer(8'hC3, 6, 8'h00);
    vx = {rxb[0], rxb[1]};
    vz = {rxb[2], rxb[3]};
    vy = {rxb[4], rxb[5]};
  endtask
  // bounded poll of the ready pin
  task automatic waitrdy;
    for (int k = 0; k < 3000 && data_ready_pin !== 1'b1; k++)
      @(negedge sys_clk);
    chk({15'h0, data_ready_pin}, 16'h0001);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    spiCsN = 1'b1;
    spiSck = 1'b1;
    spiSdi = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(8'h80, 8'h10);
    rd(8'h81, 8'h20);
    rd(8'h82, 8'h01);
    xfer(8'h01, 1, 8'hA0);
    rd(8'h81, 8'hA0);
    xfer(8'h0A, 1, 8'h5A);
    rd(8'h8A, 8'h00);
    xfer(8'h00, 1, 8'h70);
    xfer(8'h02, 1, 8'h01);
    waitrdy();
    xfer(8'h89, 1, 8'h00);
    chk({15'h0, rxb[0][0]}, 16'h0001);
    rdset();
    chk(vz - vx, 16'd201);
    chk(vy - vx, 16'hFED5);
    chk({15'h0, data_ready_pin}, 16'h0000);
    // positive then negative bias
    for (int s = 1; s <= 2; s++) begin
      xfer(8'h00, 1, 8'h70 | 8'(s));
      xfer(8'h02, 1, 8'h01);
      waitrdy();
      rdset();
      chk(vx, (s == 1) ? 16'd452 : 16'hFE3C);
      chk(vz, (s == 1) ? 16'd421 : 16'hFE5B);
      chk(vy, (s == 1) ? 16'd452 : 16'hFE3C);
      if (s == 1) begin
        chk({15'h0, $signed(vx) >= 243 && $signed(vx) <= 575}, 16'h1);
        xfer(8'h00, 1, 8'h70);
      end
    end
    xfer(8'h00, 1, 8'h70);
    xfer(8'h02, 1, 8'h01);
    waitrdy();
    rdset();
    chk(vz - vx, 16'd205);
    xfer(8'h01, 1, 8'hE0);
    chk({13'h0, gainSel}, 16'd5);
    xfer(8'h02, 1, 8'h01);
    waitrdy();
    rdset();
    chk(vz - vx, 16'd205);
    // continuous run with a set left half read
    xfer(8'h02, 1, 8'h00);
    waitrdy();
    xfer(8'hC3, 2, 8'h00);
    vx = {rxb[0], rxb[1]};
    xfer(8'h89, 1, 8'h00);
    chk({15'h0, rxb[0][1]}, 16'h0001);
    repeat (600) @(negedge sys_clk);
    xfer(8'hC5, 4, 8'h00);
    chk({rxb[0], rxb[1]} - vx, 16'd207);
    chk({rxb[2], rxb[3]} - vx, 16'hFEDB);
    xfer(8'h02, 1, 8'h03);
    conclude();
  end
endmodule
